// *** nsl_consts.svh ***
// Register offsets, field positions, reset values and timing counts of the status indicator driver.
`ifndef NSL_CONSTS_SVH
`define NSL_CONSTS_SVH

`define NSL_ADDR_W          8
`define NSL_CFG_OFFSET      8'h00
`define NSL_SRC_OFFSET      8'h04

`define NSL_NUM_SRC         7
`define NSL_CFG_RESET       16'h0084
`define NSL_CFG_WMASK       16'h60FF

`define NSL_BIT_COMBINED    15
`define NSL_BIT_POLARITY    14
`define NSL_BIT_DISABLE     13
`define NSL_BIT_STRETCH     7
`define NSL_BIT_LINK        6
`define NSL_BIT_MATCHED_RX  5
`define NSL_BIT_TRANSMIT    4
`define NSL_BIT_REV_POL     3
`define NSL_BIT_RECEIVE     2
`define NSL_BIT_JABBER      1
`define NSL_BIT_COLLISION   0

`define NSL_STAT_LINK       7
`define NSL_STAT_ACTIVE     8
`define NSL_STAT_PIN        9
`define NSL_STAT_SQE        10
`define NSL_STAT_STATE_LO   11
`define NSL_STAT_STATE_HI   12

`define NSL_CLK_PERIOD_NS   5
`define NSL_SQE_WINDOW_NS   4000
`define NSL_SQE_CYC         (`NSL_SQE_WINDOW_NS / `NSL_CLK_PERIOD_NS)
`define NSL_STRETCH_MS      50
`define NSL_CYC_PER_MS      (1000000 / `NSL_CLK_PERIOD_NS)
`define NSL_STRETCH_CYC     (`NSL_STRETCH_MS * `NSL_CYC_PER_MS)

`endif

// *** nsl_pkg.sv ***
// Types shared by the status indicator driver modules.
package nsl_pkg;

  typedef enum logic [1:0] {
    NSL_ST_IDLE = 2'b01,
    NSL_ST_HOLD = 2'b10
  } nsl_stretch_state_type;

endpackage : nsl_pkg

// *** nsl_stretch.sv ***
// Pulse stretcher that holds the indicator active after each rising occurrence.
`timescale 1ns/10ps
`default_nettype none
`include "nsl_consts.svh"

module nsl_stretch #(
  parameter int unsigned CNT_W   = 24,
  parameter int unsigned HOLD_CYC = `NSL_STRETCH_CYC
) (
  input  wire logic                          clk_i,    // Controller clock.
  input  wire logic                          rst_i,    // Synchronous reset, active high.
  input  wire logic                          enable_i, // Stretching enabled.
  input  wire logic                          level_i,  // Unstretched combined state.
  output logic                               active_o, // Stretched state.
  output nsl_pkg::nsl_stretch_state_type     state_o   // Current stretcher state.
);
  import nsl_pkg::*;

  localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(HOLD_CYC);

  logic                  level_q;
  logic [CNT_W-1:0]      cnt_q;
  logic [CNT_W-1:0]      cnt_d;
  nsl_stretch_state_type state_q;
  nsl_stretch_state_type state_d;
  wire                   rise_w = level_i & ~level_q;

  // Every new rising occurrence reloads the timer, so bursts keep the indicator lit.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      NSL_ST_IDLE: begin
        if (enable_i && rise_w) begin
          cnt_d   = HOLD_LOAD;
          state_d = NSL_ST_HOLD;
        end
      end
      NSL_ST_HOLD: begin
        if (!enable_i) begin
          cnt_d   = '0;
          state_d = NSL_ST_IDLE;
        end else if (rise_w) begin
          cnt_d = HOLD_LOAD;
        end else if (cnt_q <= CNT_W'(1)) begin
          cnt_d   = '0;
          state_d = NSL_ST_IDLE;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      default: begin
        cnt_d   = '0;
        state_d = NSL_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_q <= 1'b0;
      cnt_q   <= '0;
      state_q <= NSL_ST_IDLE;
    end else begin
      level_q <= level_i;
      cnt_q   <= cnt_d;
      state_q <= state_d;
    end
  end

  assign active_o = level_i | (enable_i & (state_q == NSL_ST_HOLD));
  assign state_o  = state_q;

endmodule : nsl_stretch
`default_nettype wire

// *** nsl_led_driver.sv ***
// Status indicator one driver: source selection, stretching, pin drive and Wishbone registers.
`timescale 1ns/10ps
`default_nettype none
`include "nsl_consts.svh"

module nsl_led_driver #(
  parameter int unsigned STRETCH_CYC = `NSL_STRETCH_CYC,
  parameter int unsigned STRETCH_W   = 24,
  parameter int unsigned SQE_CYC     = `NSL_SQE_CYC,
  parameter int unsigned SQE_W       = 10
) (
  input  wire logic                       clk_i,                  // Controller clock, 200 MHz.
  input  wire logic                       rst_i,                  // Hardware reset, synchronous, active high.
  // Wishbone classic slave.
  input  wire logic                       cyc_i,                  // Bus cycle.
  input  wire logic                       stb_i,                  // Strobe.
  input  wire logic                       we_i,                   // Write enable.
  input  wire logic [`NSL_ADDR_W-1:0]     adr_i,                  // Byte address.
  input  wire logic [3:0]                 sel_i,                  // Byte selects.
  input  wire logic [31:0]                dat_i,                  // Write data.
  output logic      [31:0]                dat_o,                  // Read data.
  output logic                            ack_o,                  // Acknowledge.
  // Network activity sources.
  input  wire logic                       link_pass_status_i,     // Twisted-pair link is pass.
  input  wire logic                       matched_receive_i,      // Address-matched receive activity.
  input  wire logic                       transmit_active_i,      // Own transmit activity.
  input  wire logic                       reversed_polarity_i,    // Receive pair reversed.
  input  wire logic                       receive_active_i,       // Any receive activity.
  input  wire logic                       jabber_i,               // Own jabber condition.
  input  wire logic                       collision_i,            // Collision activity.
  input  wire logic                       aui_selected_i,         // AUI port selected.
  input  wire logic                       transmit_done_i,        // Transmit completion pulse.
  // Open-drain or totem-pole indicator pin.
  input  wire logic                       led_pin_i,              // Pin level as seen on the wire.
  output logic                            led_pin_o,              // Pin output value.
  output logic                            led_pin_oe_n_o          // Pin output enable, low drives.
);
  import nsl_pkg::*;

  localparam logic [SQE_W-1:0] SQE_LOAD = SQE_W'(SQE_CYC);

  // Configuration and bus state.
  logic [15:0]            cfg_q;
  logic                   ack_q;
  logic [31:0]            dat_q;
  logic                   pin_q;
  logic                   oe_n_q;
  logic [SQE_W-1:0]       sqe_cnt_q;
  logic [SQE_W-1:0]       sqe_cnt_d;

  // Source conditioning and combination.
  logic [`NSL_NUM_SRC-1:0] src_w;
  logic [`NSL_NUM_SRC-1:0] gated_w;
  logic                    combined_w;
  logic                    active_w;
  logic                    sqe_window_w;
  nsl_stretch_state_type   st_state_w;

  // Collision masking window after transmit completion on the AUI port.
  assign sqe_window_w = (sqe_cnt_q != '0);

  always_comb begin
    sqe_cnt_d = sqe_cnt_q;
    if (transmit_done_i && aui_selected_i) begin
      sqe_cnt_d = SQE_LOAD;
    end else if (sqe_window_w) begin
      sqe_cnt_d = sqe_cnt_q - SQE_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sqe_cnt_q <= '0;
    end else begin
      sqe_cnt_q <= sqe_cnt_d;
    end
  end

  // Conditioned sources in register bit order.
  assign src_w[`NSL_BIT_LINK]       = link_pass_status_i;
  assign src_w[`NSL_BIT_MATCHED_RX] = matched_receive_i;
  assign src_w[`NSL_BIT_TRANSMIT]   = transmit_active_i;
  assign src_w[`NSL_BIT_REV_POL]    = reversed_polarity_i & link_pass_status_i;
  assign src_w[`NSL_BIT_RECEIVE]    = receive_active_i;
  assign src_w[`NSL_BIT_JABBER]     = jabber_i;
  assign src_w[`NSL_BIT_COLLISION]  = collision_i & ~(aui_selected_i & sqe_window_w);

  // Each source passes only when its enable bit is set.
  genvar g;
  generate
    for (g = 0; g < `NSL_NUM_SRC; g++) begin : g_src
      assign gated_w[g] = src_w[g] & cfg_q[g];
    end
  endgenerate

  // The combined state depends on the low enable field only, never on polarity.
  assign combined_w = |gated_w;

  nsl_stretch #(
    .CNT_W    (STRETCH_W),
    .HOLD_CYC (STRETCH_CYC)
  ) u_stretch (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .enable_i (cfg_q[`NSL_BIT_STRETCH]),
    .level_i  (combined_w),
    .active_o (active_w),
    .state_o  (st_state_w)
  );

  // Pin drive: open drain when polarity is zero, totem pole when one.
  wire pin_drive_w    = ~cfg_q[`NSL_BIT_DISABLE] & (cfg_q[`NSL_BIT_POLARITY] | active_w);
  wire pin_value_w    = cfg_q[`NSL_BIT_POLARITY] & active_w;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q  <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      pin_q  <= pin_value_w;
      oe_n_q <= ~pin_drive_w;
    end
  end

  assign led_pin_o      = pin_q;
  assign led_pin_oe_n_o = oe_n_q;

  // Wishbone decode.
  wire req_w      = cyc_i & stb_i;
  wire hit_cfg_w  = (adr_i[`NSL_ADDR_W-1:2] == (`NSL_ADDR_W-2)'(`NSL_CFG_OFFSET >> 2));
  wire hit_src_w  = (adr_i[`NSL_ADDR_W-1:2] == (`NSL_ADDR_W-2)'(`NSL_SRC_OFFSET >> 2));
  wire wr_cfg_w   = req_w & ack_q & we_i & hit_cfg_w;

  // Byte lane mask limited to the writable configuration bits.
  wire [15:0] lane_mask_w = {{8{sel_i[1]}}, {8{sel_i[0]}}} & `NSL_CFG_WMASK;

  // Configuration read: bit 15 is live and polarity never inverts it.
  wire [15:0] cfg_masked_w = cfg_q & `NSL_CFG_WMASK;
  wire [31:0] cfg_rd_w = {16'h0000, combined_w, cfg_masked_w[14:0]};

  // Source status read: conditioned sources, link, stretched state, pin and window.
  wire [31:0] src_rd_w = {19'h00000,
                          st_state_w,
                          sqe_window_w,
                          led_pin_i,
                          active_w,
                          link_pass_status_i,
                          src_w};

  wire [31:0] rd_mux_w = hit_cfg_w ? cfg_rd_w : (hit_src_w ? src_rd_w : 32'h0000_0000);

  // Ack rises one cycle after the request and drops the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req_w & ~ack_q;
      if (req_w && !ack_q && !we_i) begin
        dat_q <= rd_mux_w;
      end
    end
  end

  // Only the hardware reset loads defaults; apart from it only configuration writes touch this register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= `NSL_CFG_RESET;
    end else if (wr_cfg_w) begin
      cfg_q <= (cfg_q & ~lane_mask_w) | (dat_i[15:0] & lane_mask_w);
    end
  end

  // Reserved and read-only bits are dropped by the write mask and never stored.

  assign ack_o = ack_q;
  assign dat_o = dat_q;

endmodule : nsl_led_driver
`default_nettype wire

// *** nsl_led_monitor.sv ***
// Checker of register replies and pin drive of the status indicator driver.
`timescale 1ns/10ps
`default_nettype none
module nsl_led_monitor (
  input wire logic        clk_i,               // Clock.
  input wire logic        rst_i,               // Reset.
  input wire logic        cyc_i,               // Cycle.
  input wire logic        stb_i,               // Strobe.
  input wire logic        we_i,                // Write.
  input wire logic [7:0]  adr_i,               // Address.
  input wire logic [31:0] dat_i,               // Write data.
  input wire logic [31:0] dat_o,               // Read data.
  input wire logic        ack_o,               // Acknowledge.
  input wire logic        link_pass_status_i,  // Link pass.
  input wire logic        matched_receive_i,   // Matched receive.
  input wire logic        transmit_active_i,   // Transmit.
  input wire logic        reversed_polarity_i, // Reversed pair.
  input wire logic        receive_active_i,    // Receive.
  input wire logic        jabber_i,            // Jabber.
  input wire logic        collision_i,         // Collision.
  input wire logic        led_pin_o,           // Pin value.
  input wire logic        led_pin_oe_n_o       // Pin enable, low drives.
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] cfg_q;
  logic        comb;
  logic        rd0;
  assign rd0  = ack_o && !we_i && adr_i[7:2] == 6'h00;
  // Collision is left out; its masking window is judged by the bench.
  assign comb = |(cfg_q[6:1] & {link_pass_status_i, matched_receive_i, transmit_active_i,
                                reversed_polarity_i & link_pass_status_i, receive_active_i, jabber_i});
  always_ff @(posedge clk_i) begin
    if (rst_i) cfg_q <= 16'h0084;
    else if (cyc_i && stb_i && we_i && ack_o && adr_i[7:2] == 6'h00) cfg_q <= dat_i[15:0] & 16'h60FF;
  end
  chk_reset_idle: assert property ($past(rst_i) |-> led_pin_oe_n_o && !ack_o && dat_o == 32'h0)
    else $error("Outputs not idle after reset");
  chk_cfg_readback: assert property (rd0 |-> {dat_o[31:16], dat_o[14:0]} == {16'h0, $past(cfg_q[14:0])})
    else $error("Configuration readback wrong");
  chk_state_bit: assert property (rd0 && !$past(collision_i) |-> dat_o[15] == $past(comb))
    else $error("Combined state bit wrong");
  chk_link_status: assert property (ack_o && !we_i && adr_i[7:2] == 6'h01 |-> dat_o[7] == $past(link_pass_status_i))
    else $error("Link status bit wrong");
  chk_float_disable: assert property ($past(cfg_q[13]) |-> led_pin_oe_n_o)
    else $error("Disabled pin driven");
  chk_open_drain: assert property ($past(cfg_q[14:13]) == 2'b00 && !$past(cfg_q[7]) && !$past(collision_i)
    |-> led_pin_oe_n_o == !$past(comb) && (led_pin_oe_n_o || !led_pin_o))
    else $error("Open drain drive wrong");
  chk_totem_pole: assert property ($past(cfg_q[14:13]) == 2'b10 && !$past(cfg_q[7]) && !$past(collision_i)
    |-> !led_pin_oe_n_o && led_pin_o == $past(comb))
    else $error("Totem pole drive wrong");
  chk_stretch_hold: assert property (cfg_q[14:13] == 2'b10 && cfg_q[7] && $rose(comb) |=> led_pin_o [*8])
    else $error("Stretched pulse too short");
  cov_stretch: cover property (cfg_q[7] && $rose(comb));
  cov_disable: cover property (cfg_q[13] && comb);
  cov_read: cover property (rd0 && dat_o[15]);
endmodule : nsl_led_monitor
`default_nettype wire

// *** nsl_led_lamp.sv ***
// Indicator lamp on the status pin, with the pin's pull-up.
`timescale 1ns/10ps
`default_nettype none
module nsl_led_lamp (
  input  wire logic pin_drive_i, // Value driven by the controller.
  input  wire logic pin_oe_n_i,  // Low while the controller drives.
  output logic      level_o      // Level on the wire.
);
  // A released pin is pulled up to the lamp supply.
  assign level_o = pin_oe_n_i ? 1'b1 : pin_drive_i;
endmodule : nsl_led_lamp
`default_nettype wire

// *** tb.sv ***
// Self-checking testbench of the status indicator driver.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic        ack_o;
  logic        led_pin_i;
  logic        led_pin_o;
  logic        led_pin_oe_n_o;
  logic [6:0]  src = 7'h00;
  logic        aui_selected_i = 1'b0;
  logic        transmit_done_i = 1'b0;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cycles = 0;
  nsl_led_driver #(.STRETCH_CYC(20), .SQE_CYC(8)) i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .link_pass_status_i(src[6]), .matched_receive_i(src[5]), .transmit_active_i(src[4]),
    .reversed_polarity_i(src[3]), .receive_active_i(src[2]), .jabber_i(src[1]), .collision_i(src[0]),
    .aui_selected_i, .transmit_done_i, .led_pin_i, .led_pin_o, .led_pin_oe_n_o);
  nsl_led_lamp i_lamp (.pin_drive_i(led_pin_o), .pin_oe_n_i(led_pin_oe_n_o), .level_o(led_pin_i));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rc
  task automatic pin(input logic lvl, input logic oe_n);
    chk({30'h0, led_pin_oe_n_o, led_pin_i}, {30'h0, oe_n, lvl});
  endtask : pin
  task automatic drv(input logic [6:0] v);
    @(posedge clk_i);
    src <= v;
  endtask : drv
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(8'h00, 32'h0000_0084);
    rc(8'h10, 32'h0);
    wb(1'b1, 8'h00, 32'hFFFF_FFFF);
    rc(8'h00, 32'h0000_60FF);
    drv(7'h04);
    rc(8'h00, 32'h0000_E0FF);
    pin(1'b1, 1'b1);
    for (int i = 0; i < 7; i++) begin
      wb(1'b1, 8'h00, 32'h4000 | (32'h1 << i));
      drv((7'h01 << i) | ((i == 3) ? 7'h40 : 7'h00));
      rc(8'h00, 32'hC000 | (32'h1 << i));
      pin(1'b1, 1'b0);
      drv(~(7'h01 << i));
      rc(8'h00, 32'h4000 | (32'h1 << i));
      pin(1'b0, 1'b0);
    end
    wb(1'b1, 8'h00, 32'h0008);
    drv(7'h08);
    rc(8'h00, 32'h0008);
    wb(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h80, 32'h0);
    wb(1'b1, 8'h00, 32'h0004);
    drv(7'h04);
    rc(8'h00, 32'h8004);
    pin(1'b0, 1'b0);
    drv(7'h00);
    rc(8'h00, 32'h0004);
    pin(1'b1, 1'b1);
    wb(1'b1, 8'h00, 32'h4084);
    drv(7'h04);
    drv(7'h00);
    repeat (12) @(posedge clk_i);
    drv(7'h04);
    drv(7'h00);
    repeat (15) @(posedge clk_i);
    pin(1'b1, 1'b0);
    repeat (15) @(posedge clk_i);
    pin(1'b0, 1'b0);
    wb(1'b1, 8'h00, 32'h4001);
    @(posedge clk_i);
    aui_selected_i <= 1'b1;
    transmit_done_i <= 1'b1;
    @(posedge clk_i);
    transmit_done_i <= 1'b0;
    src <= 7'h01;
    rc(8'h00, 32'h4001);
    repeat (10) @(posedge clk_i);
    rc(8'h00, 32'hC001);
    drv(7'h04);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(8'h00, 32'h8084);
    pin(1'b0, 1'b0);
    final_report();
  end
endmodule : tb
bind nsl_led_driver nsl_led_monitor i_mon (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .dat_o, .ack_o,
  .link_pass_status_i, .matched_receive_i, .transmit_active_i, .reversed_polarity_i, .receive_active_i, .jabber_i,
  .collision_i, .led_pin_o, .led_pin_oe_n_o);
`default_nettype wire
